// file: rtl/ccd_pixel_pipeline_port.sv
`timescale 1ns/1ps
module ccd_pixel_pipeline_port (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // Line control from the controller
  input  wire logic       line_sync,
  input  wire logic       output_enable_n,
  // Sample timing settings
  input  wire logic [3:0] signal_sample_position,
  input  wire logic [3:0] reference_sample_position,
  input  wire logic       even_odd_mode,
  // Gain coefficients, launched against our strobe
  input  wire logic [7:0] gain_coefficient_bus,
  output logic            coefficient_strobe,
  // Raw converter sample of the previous pixel
  input  wire logic [7:0] adc_sample,
  // Corrected results
  output logic [7:0]      pixel_result_bus,
  output logic            pixel_result_bus_oe,
  output logic            eoc_n,
  // Sensor side
  output logic            transfer_gate_pulse,
  output logic            clamp_close,
  output logic            clamp_half
);

  typedef struct packed {
    pixel_port_pkg::line_state_e state;
    logic [3:0] gate_cnt;
    logic [2:0] phase;
    logic       first_slot;
    logic       even_slot;
    logic       sync_s1;
    logic       sync_s2;
    logic       oen_s1;
    logic       oen_s2;
    logic [8:0] cfg_s1;
    logic [8:0] cfg_s2;
    logic       strobe;
    logic [7:0] coef_a;
    logic [7:0] coef_b;
    logic [7:0] coef_c;
    logic       cmp_valid;
    logic [7:0] cmp_data;
    logic [7:0] result;
    logic       oe;
    logic       eoc_n;
    logic       tr;
    logic [5:0] clamp_rem;
    logic       clamp;
    logic       clamp_half;
  } port_s;

  localparam port_s RESET_ST = '{
    state:      pixel_port_pkg::ST_IDLE,
    coef_a:     pixel_port_pkg::COEF_RESET,
    coef_b:     pixel_port_pkg::COEF_RESET,
    coef_c:     pixel_port_pkg::COEF_RESET,
    oen_s1:     1'b1,
    oen_s2:     1'b1,
    eoc_n:      1'b1,
    default:    '0
  };

  port_s       st_ff;
  port_s       nxt_st;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic        fifo_pop;
  logic        fifo_push;
  logic        fifo_flush;

  // Gain-corrected sample, saturated at full scale
  function automatic logic [7:0] pga_apply(input logic [7:0] smp, input logic [7:0] code);
    logic [24:0] prod;
    logic [9:0]  sum;
    prod = 25'(smp) * 25'(code) * 25'(pixel_port_pkg::PGA_NUM);
    // Ten bits: full-scale sample plus full gain must not wrap before saturation
    sum  = 10'(smp) + 10'(prod >> pixel_port_pkg::PGA_SHIFT);
    return (sum > 10'h0ff) ? 8'hff : sum[7:0];
  endfunction : pga_apply

  // Clamp length in half-periods; an inverted window gives no clamp
  function automatic logic [5:0] clamp_halves(input logic [3:0] ss, input logic [3:0] sr,
                                              input logic eo);
    logic [5:0] base;
    logic [3:0] srl;
    base = eo ? pixel_port_pkg::CLAMP_BASE_EVODD : pixel_port_pkg::CLAMP_BASE_NORMAL;
    srl  = (sr > pixel_port_pkg::SR_MAX) ? pixel_port_pkg::SR_MAX : sr;
    if (base + 6'(ss) > 6'(srl)) return base + 6'(ss) - 6'(srl);
    return 6'h00;
  endfunction : clamp_halves

  // Results queue between the gain stage and the output bus
  pixel_fifo #(
    .W (pixel_port_pkg::DATA_W),
    .D (pixel_port_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .flush     (fifo_flush),
    .in_valid  (st_ff.cmp_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (st_ff.cmp_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // Handshake terms shared by the state update and the queue
  assign fifo_push  = st_ff.cmp_valid && fifo_in_ready;
  assign fifo_flush = (st_ff.state == pixel_port_pkg::ST_GATE);
  assign fifo_pop   = (st_ff.state == pixel_port_pkg::ST_CONVERT) &&
                      (st_ff.phase == pixel_port_pkg::PH_DRAIN) && fifo_out_valid;

  // Next-state logic for the whole port
  always_comb begin
    nxt_st = st_ff;

    // Sync, enable and setting pins pass two flops before use; coefficient and sample buses do not
    nxt_st.sync_s1 = line_sync;
    nxt_st.sync_s2 = st_ff.sync_s1;
    nxt_st.oen_s1  = output_enable_n;
    nxt_st.oen_s2  = st_ff.oen_s1;
    nxt_st.cfg_s1  = {even_odd_mode, signal_sample_position, reference_sample_position};
    nxt_st.cfg_s2  = st_ff.cfg_s1;

    // Bus drive follows the enable; lags the pin by the two sync flops and its own flop
    nxt_st.oe = !st_ff.oen_s2;

    // Gain stage output leaves once the queue takes it
    if (fifo_push) nxt_st.cmp_valid = 1'b0;

    // Default for the transfer gate pulse
    nxt_st.tr = 1'b0;

    unique case (st_ff.state)
      pixel_port_pkg::ST_IDLE: begin
        nxt_st.strobe = 1'b0;
        nxt_st.eoc_n  = 1'b1;
        if (st_ff.sync_s2) begin
          nxt_st.state    = pixel_port_pkg::ST_GATE;
          nxt_st.gate_cnt = pixel_port_pkg::TR_CYCLES;
          nxt_st.tr       = 1'b1;
        end
      end

      pixel_port_pkg::ST_GATE: begin
        // One gate pulse, then the first slot; coefficients back to unity gain
        nxt_st.coef_a    = pixel_port_pkg::COEF_RESET;
        nxt_st.coef_b    = pixel_port_pkg::COEF_RESET;
        nxt_st.coef_c    = pixel_port_pkg::COEF_RESET;
        nxt_st.cmp_valid = 1'b0;
        if (!st_ff.sync_s2) begin
          nxt_st.state = pixel_port_pkg::ST_IDLE;
        end else if (st_ff.gate_cnt > 4'h1) begin
          nxt_st.gate_cnt = st_ff.gate_cnt - 4'h1;
          nxt_st.tr       = 1'b1;
        end else begin
          nxt_st.state      = pixel_port_pkg::ST_CONVERT;
          nxt_st.phase      = 3'h0;
          nxt_st.first_slot = 1'b1;
          nxt_st.even_slot  = 1'b0;
          nxt_st.clamp_rem  = clamp_halves(st_ff.cfg_s2[7:4], st_ff.cfg_s2[3:0],
                                           st_ff.cfg_s2[8]);
        end
      end

      pixel_port_pkg::ST_CONVERT: begin
        // Runs until line sync falls; no pixel count anywhere
        if (!st_ff.sync_s2) begin
          nxt_st.state  = pixel_port_pkg::ST_IDLE;
          nxt_st.strobe = 1'b0;
          nxt_st.eoc_n  = 1'b1;
        end else begin
          nxt_st.phase = st_ff.phase + 3'h1;

          // Strobe high for the second half of every slot
          if (st_ff.phase == pixel_port_pkg::PH_CAPTURE) begin
            nxt_st.strobe = 1'b1;
            // Slot s takes the coefficient of pixel s+1, so pixel 1 never gets one
            nxt_st.coef_a = gain_coefficient_bus;
            nxt_st.coef_b = st_ff.coef_a;
            nxt_st.coef_c = st_ff.coef_b;
          end else if (st_ff.phase == pixel_port_pkg::PH_LAST) begin
            nxt_st.strobe = 1'b0;
          end

          // Result of pixel s-1 from coefficient captured two slots ago
          if (st_ff.phase == pixel_port_pkg::PH_COMPUTE && !st_ff.first_slot &&
              !st_ff.cmp_valid) begin
            nxt_st.cmp_data  = pga_apply(adc_sample, st_ff.coef_c);
            nxt_st.cmp_valid = 1'b1;
          end

          // End-of-conversion low for two cycles when a result is ready
          if (fifo_pop) begin
            nxt_st.result = fifo_out_data;
            nxt_st.eoc_n  = 1'b0;
          end else if (st_ff.phase == pixel_port_pkg::PH_EOC_END) begin
            nxt_st.eoc_n = 1'b1;
          end

          // Slot boundary: reload the clamp window
          if (st_ff.phase == pixel_port_pkg::PH_LAST) begin
            nxt_st.first_slot = 1'b0;
            nxt_st.even_slot  = !st_ff.even_slot;
            // Even/odd sensors clamp across a pixel pair, so reload every second slot
            if (!st_ff.cfg_s2[8] || st_ff.even_slot) begin
              nxt_st.clamp_rem = clamp_halves(st_ff.cfg_s2[7:4], st_ff.cfg_s2[3:0],
                                              st_ff.cfg_s2[8]);
            end
          end
        end
      end
    endcase

    // Clamp window counted down in half-periods, two per cycle
    if (st_ff.state == pixel_port_pkg::ST_CONVERT && st_ff.sync_s2) begin
      nxt_st.clamp      = (st_ff.clamp_rem != 6'h00);
      nxt_st.clamp_half = (st_ff.clamp_rem == 6'h01);
      if (st_ff.phase != pixel_port_pkg::PH_LAST ||
          (st_ff.cfg_s2[8] && !st_ff.even_slot)) begin
        nxt_st.clamp_rem = (st_ff.clamp_rem > 6'h02) ? st_ff.clamp_rem - 6'h02 : 6'h00;
      end
    end else begin
      nxt_st.clamp      = 1'b0;
      nxt_st.clamp_half = 1'b0;
      if (st_ff.state != pixel_port_pkg::ST_GATE) nxt_st.clamp_rem = 6'h00;
    end
  end

  // Single state register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) st_ff <= RESET_ST;
    else st_ff <= nxt_st;
  end

  // All outputs straight from flops
  assign coefficient_strobe  = st_ff.strobe;
  assign pixel_result_bus    = st_ff.result;
  assign pixel_result_bus_oe = st_ff.oe;
  assign eoc_n               = st_ff.eoc_n;
  assign transfer_gate_pulse = st_ff.tr;
  assign clamp_close         = st_ff.clamp;
  assign clamp_half          = st_ff.clamp_half;

endmodule : ccd_pixel_pipeline_port

// file: rtl/pixel_fifo.sv
`timescale 1ns/1ps
module pixel_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic         flush,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } fifo_s;

  fifo_s        st_ff;
  fifo_s        nxt_st;
  logic [W-1:0] mem [D];
  logic         push;
  logic         pop;

  // Honest flags straight from the count
  assign in_ready  = (st_ff.cnt != (AW+1)'(D));
  assign out_valid = (st_ff.cnt != '0);
  assign out_data  = mem[st_ff.rd];
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;

  // Pointer and count update; flush wins over both sides
  always_comb begin
    nxt_st = st_ff;
    if (flush) begin
      nxt_st = '0;
    end else begin
      if (push) nxt_st.wr = st_ff.wr + AW'(1);
      if (pop) nxt_st.rd = st_ff.rd + AW'(1);
      nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) st_ff <= '0;
    else st_ff <= nxt_st;
  end

  // Storage has no reset; contents only matter behind the count
  always_ff @(posedge mclk) begin
    if (push) mem[st_ff.wr] <= in_data;
  end

endmodule : pixel_fifo

// file: rtl/pixel_port_pkg.sv
package pixel_port_pkg;

  // Clock and pixel slot
  localparam int        MCLK_KHZ      = 10000;
  localparam int        SLOT_CYCLES   = 8;
  localparam logic [2:0] PH_CAPTURE   = 3'h3;
  localparam logic [2:0] PH_COMPUTE   = 3'h4;
  localparam logic [2:0] PH_DRAIN     = 3'h6;
  localparam logic [2:0] PH_LAST      = 3'h7;
  localparam logic [2:0] PH_EOC_END   = 3'h0;

  // Transfer gate pulse width
  localparam int        TR_NS         = 800;
  localparam int        TR_CYCLES_I   = (TR_NS * MCLK_KHZ) / 1000000;
  localparam logic [3:0] TR_CYCLES    = 4'(TR_CYCLES_I < 1 ? 1 : TR_CYCLES_I);

  // Clamp window bases in half-periods of the master clock
  localparam logic [5:0] CLAMP_BASE_NORMAL = 6'h02;
  localparam logic [5:0] CLAMP_BASE_EVODD  = 6'h12;
  localparam logic [3:0] SR_MAX            = 4'he;

  // Gain: 1 + code * 500 / 65536, close to 1 + code * 1.95 / 256
  localparam logic [8:0] PGA_NUM   = 9'h1f4;
  localparam int         PGA_SHIFT = 16;

  // Result path and reset values
  localparam int         DATA_W     = 8;
  localparam int         FIFO_DEPTH = 16;
  localparam logic [7:0] COEF_RESET = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_GATE,
    ST_CONVERT
  } line_state_e;

endpackage : pixel_port_pkg

// file: tb/ccd_pixel_pipeline_port_tb.sv
`timescale 1ns/1ps
module ccd_pixel_pipeline_port_tb;
  logic       mclk, rstn, line_sync, output_enable_n, even_odd_mode;
  logic [3:0] sig_pos, ref_pos;
  logic [7:0] coef_bus, adc, res_o, px_bus, n_res;
  logic       strobe, oe, eoc_n, tr, clamp, half;
  int         n_mismatch, n_compared;

  // Released bus shows the inverse of its last value
  assign px_bus = oe ? res_o : ~res_o;

  ccd_pixel_pipeline_port u_ccd_pixel_pipeline_port (.mclk, .rstn, .line_sync, .output_enable_n,
    .signal_sample_position(sig_pos), .reference_sample_position(ref_pos), .even_odd_mode,
    .gain_coefficient_bus(coef_bus), .coefficient_strobe(strobe), .adc_sample(adc),
    .pixel_result_bus(res_o), .pixel_result_bus_oe(oe), .eoc_n, .transfer_gate_pulse(tr),
    .clamp_close(clamp), .clamp_half(half));
  scan_ctrl_model u_scan_ctrl_model (.mclk, .rstn, .coefficient_strobe(strobe), .eoc_n,
    .transfer_gate_pulse(tr), .result_bus(px_bus), .gain_coefficient_bus(coef_bus),
    .adc_sample(adc), .n_res);

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // Gain law with saturation; first pixel has unity gain
  function automatic logic [7:0] exp_px(input int p);
    int g;
    g = (p == 1) ? 128 : 128 + ((128 * ((p * 37) % 256) * 500) >> 16);
    exp_px = (g > 255) ? 8'hff : 8'(g);
  endfunction : exp_px

  // Line length set only by how long sync stays high
  task automatic run_line(input int slots, input logic eo,
                          input logic [3:0] s, input logic [3:0] r);
    even_odd_mode <= eo;
    sig_pos       <= s;
    ref_pos       <= r;
    repeat (20) @(posedge mclk);
    line_sync <= 1'b1;
    repeat (11 + 8 * slots) @(posedge mclk);
    line_sync <= 1'b0;
    repeat (24) @(posedge mclk);
  endtask : run_line

  task automatic test_normal_line;
    run_line(10, 1'b0, 4'h5, 4'h0);
    for (int p = 1; p <= 8; p++) check(u_scan_ctrl_model.res[p-1], exp_px(p));
    check(n_res, 8'h09);
    $display("test normal_line done");
  endtask : test_normal_line

  task automatic test_long_evodd;
    run_line(40, 1'b1, 4'hf, 4'he);
    check(n_res, 8'h27);
    check(u_scan_ctrl_model.res[38], exp_px(39));
    $display("test long_evodd done");
  endtask : test_long_evodd

  task automatic test_enable;
    output_enable_n <= 1'b1;
    repeat (5) @(posedge mclk);
    check({7'h0, oe}, 8'h00);
    output_enable_n <= 1'b0;
    repeat (5) @(posedge mclk);
    check({7'h0, oe}, 8'h01);
    $display("test enable done");
  endtask : test_enable

  // Sync dropped inside the gate pulse must not start conversion
  task automatic test_abort;
    line_sync <= 1'b1;
    repeat (3) @(posedge mclk);
    line_sync <= 1'b0;
    repeat (40) @(posedge mclk);
    check(n_res, 8'h00);
    $display("test abort done");
  endtask : test_abort

  initial begin
    rstn            = 1'b0;
    line_sync       = 1'b0;
    output_enable_n = 1'b0;
    even_odd_mode   = 1'b0;
    sig_pos         = 4'h0;
    ref_pos         = 4'h0;
    n_mismatch      = 0;
    n_compared      = 0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    test_normal_line();
    test_long_evodd();
    test_enable();
    test_abort();
    report_and_stop();
  end

  // Whole run needs under a thousand cycles
  initial begin
    #(100 * 2500);
    n_mismatch++;
    report_and_stop();
  end
endmodule : ccd_pixel_pipeline_port_tb

// file: tb/pixel_port_asserts.sv
`timescale 1ns/1ps
module pixel_port_asserts (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rstn,
  // Controls
  input wire logic       line_sync,
  input wire logic       output_enable_n,
  input wire logic [3:0] signal_sample_position,
  input wire logic [3:0] reference_sample_position,
  input wire logic       even_odd_mode,
  // Outputs watched
  input wire logic       coefficient_strobe,
  input wire logic [7:0] pixel_result_bus,
  input wire logic       pixel_result_bus_oe,
  input wire logic       eoc_n,
  input wire logic       transfer_gate_pulse,
  input wire logic       clamp_close,
  input wire logic       clamp_half
);
  logic [1:0] up_ff;
  logic [3:0] low_ff;
  logic [4:0] run_ff;
  logic [3:0] tr_ff;
  logic [6:0] n_half;

  // Reference position 15 acts as 14
  assign n_half = (even_odd_mode ? 7'h12 : 7'h02) + {3'h0, signal_sample_position}
                - ((reference_sample_position == 4'hf) ? 7'h0e : {3'h0, reference_sample_position});

  // Run counters; the enable check waits out the synchroniser
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      up_ff  <= 2'h0;
      low_ff <= 4'h0;
      run_ff <= 5'h00;
      tr_ff  <= 4'h0;
    end else begin
      up_ff  <= (up_ff == 2'h3) ? up_ff : up_ff + 2'h1;
      low_ff <= line_sync ? 4'h0 : ((low_ff == 4'hf) ? low_ff : low_ff + 4'h1);
      run_ff <= clamp_close ? run_ff + 5'h01 : 5'h00;
      tr_ff  <= transfer_gate_pulse ? tr_ff + 4'h1 : 4'h0;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  chk_oe_follow: assert property (
    up_ff == 2'h3 |-> pixel_result_bus_oe == !$past(output_enable_n, 3))
    else $error("result enable wrong");
  chk_strobe_width: assert property (
    $rose(coefficient_strobe) |=> coefficient_strobe[*3] ##1 !coefficient_strobe)
    else $error("strobe width wrong");
  chk_eoc_period: assert property (
    $fell(eoc_n) |=> !eoc_n ##1 eoc_n[*6])
    else $error("conversion strobe timing wrong");
  chk_result_hold: assert property (
    !eoc_n && !$fell(eoc_n) |-> $stable(pixel_result_bus))
    else $error("result moved while valid");
  chk_idle_quiet: assert property (
    low_ff == 4'hf |-> eoc_n && !coefficient_strobe && !transfer_gate_pulse)
    else $error("activity outside a line");
  // Two sync flops and the state register put the gate pulse three edges after sync
  chk_tr_start: assert property (
    $rose(line_sync) && low_ff == 4'hf |-> ##3 $rose(transfer_gate_pulse))
    else $error("gate pulse late");
  chk_tr_width: assert property (
    $fell(transfer_gate_pulse) && line_sync |-> tr_ff == 4'h8)
    else $error("gate pulse width wrong");
  chk_first_strobe: assert property (
    $fell(transfer_gate_pulse) && line_sync |-> ##4 $rose(coefficient_strobe))
    else $error("first slot misplaced");
  // Full windows only; a window cut by the line end is judged by chk_clamp_cut
  chk_clamp_len: assert property (
    $fell(clamp_close) && low_ff == 4'h0 |-> run_ff == 5'((n_half + 7'h01) >> 1))
    else $error("clamp length wrong");
  chk_clamp_half: assert property (
    $fell(clamp_close) && low_ff == 4'h0 |-> $past(clamp_half) == n_half[0])
    else $error("clamp half step wrong");
  chk_clamp_cut: assert property (
    $fell(clamp_close) && low_ff != 4'h0 |-> run_ff <= 5'((n_half + 7'h01) >> 1))
    else $error("cut clamp too long");

  cover property ($fell(eoc_n));
  cover property ($fell(clamp_close) && even_odd_mode);
  cover property ($fell(transfer_gate_pulse) && !line_sync);
endmodule : pixel_port_asserts

bind ccd_pixel_pipeline_port pixel_port_asserts u_pixel_port_asserts (.mclk, .rstn, .line_sync,
  .output_enable_n, .signal_sample_position, .reference_sample_position, .even_odd_mode,
  .coefficient_strobe, .pixel_result_bus, .pixel_result_bus_oe, .eoc_n, .transfer_gate_pulse,
  .clamp_close, .clamp_half);

// file: tb/scan_ctrl_model.sv
`timescale 1ns/1ps
module scan_ctrl_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // Device side
  input  wire logic       coefficient_strobe,
  input  wire logic       eoc_n,
  input  wire logic       transfer_gate_pulse,
  input  wire logic [7:0] result_bus,
  output logic      [7:0] gain_coefficient_bus,
  output logic      [7:0] adc_sample,
  // Captured results
  output logic      [7:0] n_res
);
  logic [7:0] res [64];
  logic [7:0] idx_ff;
  logic       strobe_ff;
  logic       eoc_ff;

  // Fixed raw level keeps expected results simple
  assign adc_sample = 8'h80;

  // Coefficients run one pixel ahead of the strobe
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      idx_ff               <= 8'h00;
      strobe_ff            <= 1'b0;
      eoc_ff               <= 1'b1;
      n_res                <= 8'h00;
      gain_coefficient_bus <= 8'h00;
    end else begin
      strobe_ff <= coefficient_strobe;
      eoc_ff    <= eoc_n;
      if (transfer_gate_pulse) begin
        idx_ff               <= 8'h02;
        gain_coefficient_bus <= 8'(8'h02 * 8'h25);
        n_res                <= 8'h00;
      end else if (coefficient_strobe && !strobe_ff) begin
        idx_ff               <= idx_ff + 8'h01;
        gain_coefficient_bus <= 8'((idx_ff + 8'h01) * 8'h25);
      end
      // Memory write on the rising end-of-conversion edge
      if (eoc_n && !eoc_ff) begin
        res[n_res[5:0]] <= result_bus;
        n_res           <= n_res + 8'h01;
      end
    end
  end
endmodule : scan_ctrl_model
